// file: pbc_defines.svh
// Register map, field positions and reset values of the port block
`ifndef PBC_DEFINES_SVH
`define PBC_DEFINES_SVH

// ============================================================
// Register indices (byte address is four times the index)
`define PBC_IDX_PORT_PIN_DATA     10'h006
`define PBC_IDX_INTERRUPT_CONTROL 10'h00b
`define PBC_IDX_OPTION_CONFIG     10'h081
`define PBC_IDX_PORT_DIRECTION    10'h086
`define PBC_IDX_PROG_MODE_CTRL    10'h090

// ============================================================
// Field positions
`define PBC_BIT_GLOBAL_IRQ_EN     7
`define PBC_BIT_PERIPH_IRQ_EN     6
`define PBC_BIT_TIMER_IRQ_EN      5
`define PBC_BIT_EXT_IRQ_EN        4
`define PBC_BIT_CHANGE_IRQ_EN     3
`define PBC_BIT_TIMER_FLAG        2
`define PBC_BIT_EXT_FLAG          1
`define PBC_BIT_CHANGE_FLAG       0
`define PBC_BIT_PULLUP_DISABLE_N  7
`define PBC_BIT_EXT_EDGE_SELECT   6
`define PBC_PIN_EXT               0
`define PBC_PIN_PROG              3

// ============================================================
// Reset values
`define PBC_RST_INTERRUPT_CONTROL 8'h00
`define PBC_RST_OPTION_CONFIG     8'hff
`define PBC_RST_PORT_DIRECTION    8'hff
`define PBC_RST_PORT_LATCH        8'h00
`define PBC_RST_PROG_MODE         1'b1
`define PBC_RDATA_ZERO            32'h0000_0000

`endif

// file: pbc_pkg.sv
// Types shared by the port block
`default_nettype none

package pbc_pkg;

  // ============================================================
  // Interrupt control register layout, bit 7 first
  typedef struct packed {
    logic global_irq_enable;
    logic periph_irq_enable;
    logic timer_overflow_irq_enable;
    logic ext_pin_irq_enable;
    logic change_irq_enable;
    logic timer_overflow_flag;
    logic ext_pin_irq_flag;
    logic change_irq_flag;
  } pbc_intctl_t;

  // ============================================================
  // Register selected by an APB address
  typedef enum logic [2:0] {
    PBC_SEL_NONE,
    PBC_SEL_PORT,
    PBC_SEL_INTCTL,
    PBC_SEL_OPTION,
    PBC_SEL_DIR,
    PBC_SEL_PROG
  } pbc_sel_t;

endpackage : pbc_pkg

`default_nettype wire

// file: pbc_port.sv
// Eight-bit port with pull-ups, change and edge interrupts, APB slave
//
// Decided for this implementation: the APB register port.
`include "pbc_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module pbc_port (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr,
  // Port pins
  input  wire logic [7:0]  i_pin_in,
  output logic [7:0]       o_pin_out,
  output logic [7:0]       o_pin_oe,
  output logic [7:0]       o_pullup_en,
  // Peripheral direction override, direction 1 means input
  input  wire logic [7:0]  i_periph_dir_en,
  input  wire logic [7:0]  i_periph_dir,
  // Other interrupt sources
  input  wire logic        i_timer_overflow,
  input  wire logic        i_periph_irq,
  // Interrupt request and wake
  output logic             o_irq,
  output logic             o_wake
);

  // ============================================================
  // State
  pbc_pkg::pbc_intctl_t intctl;
  logic [7:0]           option_config;
  logic [7:0]           port_direction;
  logic [7:0]           port_latch;
  logic [7:4]           change_copy;
  logic                 ext_pin_prev;
  logic                 prog_mode;

  // ============================================================
  // Address decode
  function automatic pbc_pkg::pbc_sel_t decode(input logic [11:0] addr);
    pbc_pkg::pbc_sel_t sel;
    sel = pbc_pkg::PBC_SEL_NONE;
    if (addr[1:0] != 2'h0) begin
      sel = pbc_pkg::PBC_SEL_NONE;
    end else if (addr[11:2] == `PBC_IDX_PORT_PIN_DATA) begin
      sel = pbc_pkg::PBC_SEL_PORT;
    end else if (addr[11:2] == `PBC_IDX_INTERRUPT_CONTROL) begin
      sel = pbc_pkg::PBC_SEL_INTCTL;
    end else if (addr[11:2] == `PBC_IDX_OPTION_CONFIG) begin
      sel = pbc_pkg::PBC_SEL_OPTION;
    end else if (addr[11:2] == `PBC_IDX_PORT_DIRECTION) begin
      sel = pbc_pkg::PBC_SEL_DIR;
    end else if (addr[11:2] == `PBC_IDX_PROG_MODE_CTRL) begin
      sel = pbc_pkg::PBC_SEL_PROG;
    end
    return sel;
  endfunction : decode

  pbc_pkg::pbc_sel_t sel;
  logic              access_done;
  logic              wr_done;
  logic              rd_done;
  logic              port_touch;

  assign sel         = decode(i_paddr);
  // Access completes at the edge where pready is seen high
  assign access_done = i_psel & i_penable & o_pready;
  assign wr_done     = access_done & i_pwrite;
  assign rd_done     = access_done & ~i_pwrite;
  assign port_touch  = access_done & (sel == pbc_pkg::PBC_SEL_PORT);

  // ============================================================
  // Effective direction and pin view
  logic [7:0] eff_dir;
  logic [7:0] pin_view;
  logic [3:0] mismatch;
  logic       change_event;
  logic       ext_event;

  always_comb begin
    // Peripheral override wins over the direction register
    eff_dir = (i_periph_dir_en & i_periph_dir)
            | (~i_periph_dir_en & port_direction);
    // Programming mode owns pin 3, so it is held as an input
    if (prog_mode) begin
      eff_dir[`PBC_PIN_PROG] = 1'b1;
    end
  end

  always_comb begin
    pin_view = i_pin_in;
    if (prog_mode) begin
      pin_view[`PBC_PIN_PROG] = 1'b0;
    end
  end

  // Only input pins can mismatch
  assign mismatch     = (i_pin_in[7:4] ^ change_copy)
                      & eff_dir[7:4];
  assign change_event = |mismatch;

  // Edge detect on the external interrupt pin
  assign ext_event = option_config[`PBC_BIT_EXT_EDGE_SELECT]
                   ? (i_pin_in[`PBC_PIN_EXT] & ~ext_pin_prev)
                   : (~i_pin_in[`PBC_PIN_EXT] & ext_pin_prev);

  // ============================================================
  // APB answer, zero wait states from a flop
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= `PBC_RDATA_ZERO;
    end else begin
      o_pready  <= i_psel & ~i_penable;
      o_pslverr <= i_psel & ~i_penable & (sel == pbc_pkg::PBC_SEL_NONE);
      o_prdata  <= `PBC_RDATA_ZERO;
      if (i_psel && !i_penable && !i_pwrite) begin
        if (sel == pbc_pkg::PBC_SEL_PORT) begin
          o_prdata <= {24'h00_0000, pin_view};
        end else if (sel == pbc_pkg::PBC_SEL_INTCTL) begin
          o_prdata <= {24'h00_0000, intctl};
        end else if (sel == pbc_pkg::PBC_SEL_OPTION) begin
          o_prdata <= {24'h00_0000, option_config};
        end else if (sel == pbc_pkg::PBC_SEL_DIR) begin
          o_prdata <= {24'h00_0000, port_direction};
        end else if (sel == pbc_pkg::PBC_SEL_PROG) begin
          o_prdata <= {31'h0000_0000, prog_mode};
        end
      end
    end
  end

  // ============================================================
  // Configuration registers
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      option_config  <= `PBC_RST_OPTION_CONFIG;
      port_direction <= `PBC_RST_PORT_DIRECTION;
      prog_mode      <= `PBC_RST_PROG_MODE;
    end else if (wr_done) begin
      if (sel == pbc_pkg::PBC_SEL_OPTION) begin
        option_config <= i_pwdata[7:0];
      end
      if (sel == pbc_pkg::PBC_SEL_DIR) begin
        port_direction <= i_pwdata[7:0];
      end
      if (sel == pbc_pkg::PBC_SEL_PROG) begin
        prog_mode <= i_pwdata[0];
      end
    end
  end

  // Output latch
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      port_latch <= `PBC_RST_PORT_LATCH;
    end else if (wr_done && sel == pbc_pkg::PBC_SEL_PORT) begin
      port_latch <= i_pwdata[7:0];
    end
  end

  // ============================================================
  // Change comparison copy and edge history
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      change_copy  <= 4'h0;
      ext_pin_prev <= 1'b0;
    end else begin
      ext_pin_prev <= i_pin_in[`PBC_PIN_EXT];
      // Reads and writes both refresh; polling therefore hides changes
      if (port_touch) begin
        change_copy <= i_pin_in[7:4];
      end
    end
  end

  // ============================================================
  // Interrupt control: enables written, flags set wins over clear
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      intctl <= `PBC_RST_INTERRUPT_CONTROL;
    end else begin
      if (wr_done && sel == pbc_pkg::PBC_SEL_INTCTL) begin
        intctl <= i_pwdata[7:0];
      end
      // Flags ignore enables entirely
      if (i_timer_overflow) begin
        intctl.timer_overflow_flag <= 1'b1;
      end
      if (ext_event) begin
        intctl.ext_pin_irq_flag <= 1'b1;
      end
      // A live mismatch keeps setting the flag, so a clear needs a port read or write first
      if (change_event && !port_touch) begin
        intctl.change_irq_flag <= 1'b1;
      end
    end
  end

  // ============================================================
  // Pin drivers, pull-ups, request and wake from flops
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_pin_out   <= 8'h00;
      o_pin_oe    <= 8'h00;
      o_pullup_en <= 8'h00;
      o_irq       <= 1'b0;
      o_wake      <= 1'b0;
    end else begin
      o_pin_out   <= port_latch;
      o_pin_oe    <= ~eff_dir;
      o_pullup_en <= {8{~option_config[`PBC_BIT_PULLUP_DISABLE_N]}}
                   & eff_dir;
      o_irq <= intctl.global_irq_enable & (
                 (intctl.timer_overflow_irq_enable
                  & intctl.timer_overflow_flag)
               | (intctl.ext_pin_irq_enable
                  & intctl.ext_pin_irq_flag)
               | (intctl.change_irq_enable & intctl.change_irq_flag)
               | (intctl.periph_irq_enable & i_periph_irq));
      // Wake does not need the global enable
      o_wake <= intctl.change_irq_enable & intctl.change_irq_flag;
    end
  end

endmodule : pbc_port

`default_nettype wire

// file: pbc_port_assertions.sv
// Port-level checker of the port block
`include "pbc_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module pbc_port_chk (
  // Clock, reset and APB
  input wire logic        i_clk,
  input wire logic        i_rstn,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic        o_pready,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pslverr,
  // Pins and interrupts
  input wire logic [7:0]  i_pin_in,
  input wire logic [7:0]  o_pin_out,
  input wire logic [7:0]  o_pin_oe,
  input wire logic [7:0]  o_pullup_en,
  input wire logic [7:0]  i_periph_dir_en,
  input wire logic [7:0]  i_periph_dir,
  input wire logic        i_timer_overflow,
  input wire logic        i_periph_irq,
  input wire logic        o_irq,
  input wire logic        o_wake
);
  // ============================================================
  // Checks
  localparam logic [11:0] r_int = {`PBC_IDX_INTERRUPT_CONTROL, 2'b00};
  logic int_wr;
  assign int_wr = i_psel & i_penable & o_pready & i_pwrite & (i_paddr == r_int);
  default clocking dflt @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  a_pull_off_out:
    assert property ((o_pullup_en & o_pin_oe) == 8'h00)
    else $error("pull-up on a driven pin");
  a_reset_quiet:
    assert property ($rose(i_rstn) |-> o_pullup_en == 8'h00 && o_pin_oe == 8'h00)
    else $error("pins not quiet after reset");
  // Pin 3 is left out: programming mode may own it
  a_oe_override:
    assert property ($past(i_rstn) |-> ((o_pin_oe ^ ~$past(i_periph_dir))
      & $past(i_periph_dir_en) & 8'hf7) == 8'h00)
    else $error("override direction ignored");
  a_ready_setup:
    assert property (i_psel && !i_penable |=> o_pready)
    else $error("no ready after setup");
  a_ready_pulse:
    assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  a_err_zero:
    assert property (o_pslverr |-> o_pready && o_prdata == 32'h0000_0000)
    else $error("error response carries data");
  a_gie_off:
    assert property (int_wr && !i_pwdata[7] |-> ##2 !o_irq)
    else $error("request with global enable off");
  a_wake_off:
    assert property (int_wr && !i_pwdata[3] |-> ##2 !o_wake)
    else $error("wake with change enable off");
  c_irq: cover property ($rose(o_irq));
  c_wake: cover property ($rose(o_wake));
  c_err: cover property (o_pslverr);
endmodule : pbc_port_chk

bind pbc_port pbc_port_chk i_chk (.*);

`default_nettype wire

// file: pbc_pins.sv
// Pin model: resolves each pin from block driver, bench and pull-up
`timescale 1ns/1ps
`default_nettype none

module pbc_pins (
  // Block side
  input  wire logic       i_clk,
  input  wire logic [7:0] i_out,
  input  wire logic [7:0] i_oe,
  input  wire logic [7:0] i_pullup,
  // Bench side
  input  wire logic [7:0] i_drv_en,
  input  wire logic [7:0] i_drv,
  output logic [7:0]      o_level
);
  // ============================================================
  // Resolution
  // A floating pin toggles so it never settles to a lucky value
  logic [7:0] float_pat = 8'h55;
  always @(posedge i_clk) float_pat <= ~float_pat;
  assign o_level = (i_oe & i_out)
                 | (~i_oe & i_drv_en & i_drv)
                 | (~i_oe & ~i_drv_en & (i_pullup | float_pat));
endmodule : pbc_pins

`default_nettype wire

// file: tb.sv
// Self-checking testbench of the port block
`include "pbc_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module tb;
  // ============================================================
  // Bench
  localparam logic [11:0] r_port = {`PBC_IDX_PORT_PIN_DATA, 2'b00};
  localparam logic [11:0] r_int  = {`PBC_IDX_INTERRUPT_CONTROL, 2'b00};
  localparam logic [11:0] r_opt  = {`PBC_IDX_OPTION_CONFIG, 2'b00};
  localparam logic [11:0] r_dir  = {`PBC_IDX_PORT_DIRECTION, 2'b00};
  localparam logic [11:0] r_prog = {`PBC_IDX_PROG_MODE_CTRL, 2'b00};
  logic        i_clk, i_rstn, i_psel, i_penable, i_pwrite, o_pready, o_irq;
  logic        o_pslverr, i_timer_overflow, i_periph_irq, o_wake, last_err;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata;
  logic [7:0]  i_pin_in, o_pin_out, o_pin_oe, o_pullup_en, drv_en, drv;
  logic [7:0]  i_periph_dir_en, i_periph_dir;
  int          n_fail, n_compared;

  always #12.5 i_clk = ~i_clk;
  pbc_port i_dut (.*);
  pbc_pins i_pins (.i_clk, .i_out(o_pin_out), .i_oe(o_pin_oe),
    .i_pullup(o_pullup_en), .i_drv_en(drv_en), .i_drv(drv), .o_level(i_pin_in));

  task automatic chk(input string n, input logic [7:0] s, e);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // APB transfer; read data is compared with d
  // Waits for pready with no cycle limit; only the watchdog ends a hang
  task automatic ap(input logic [11:0] a, input logic w, input logic [7:0] d);
    @(posedge i_clk);
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'b10, w, a, 24'h0, d};
    @(posedge i_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk);
    end while (o_pready !== 1'b1);
    last_err = o_pslverr;
    if (!w) chk($sformatf("reg %h", a), o_prdata[7:0], d);
    {i_psel, i_penable} <= 2'b00;
  endtask : ap

  // Interrupt control write, then request level check
  task automatic wi(input logic [7:0] d, input logic e);
    ap(r_int, 1'b1, d);
    repeat (3) @(negedge i_clk);
    chk("irq", {7'h0, o_irq}, {7'h0, e});
    // Return on a rising edge so callers drive inputs there
    @(posedge i_clk);
  endtask : wi

  task automatic t_reset;
    chk("pullup", o_pullup_en, 8'h00);
    chk("oe", o_pin_oe, 8'h00);
    ap(r_dir, 1'b0, 8'hff);
    ap(r_opt, 1'b0, 8'hff);
    $display("reset test done");
  endtask : t_reset

  task automatic t_dir;
    ap(r_port, 1'b1, 8'h5a);
    ap(r_dir, 1'b1, 8'h0f);
    {drv, i_periph_dir_en} <= 16'h0f01;
    repeat (3) @(negedge i_clk);
    chk("oe", o_pin_oe, 8'hf1);
    chk("out", o_pin_out, 8'h5a);
    ap(r_port, 1'b0, 8'h56);
    i_periph_dir_en <= 8'h00;
    ap(r_prog, 1'b1, 8'h00);
    ap(r_port, 1'b0, 8'h5f);
    ap(r_opt, 1'b1, 8'h7f);
    repeat (3) @(negedge i_clk);
    chk("pullup", o_pullup_en, 8'h0f);
    @(posedge i_clk);
    drv_en <= 8'hf0;
    ap(r_port, 1'b0, 8'h5f);
    {drv_en, drv} <= 16'hff00;
    ap(r_opt, 1'b1, 8'hff);
    $display("direction test done");
  endtask : t_dir

  // Port is not polled while a change is awaited
  task automatic t_change;
    ap(r_dir, 1'b1, 8'hff);
    ap(r_port, 1'b0, 8'h00);
    ap(r_int, 1'b1, 8'h00);
    ap(r_int, 1'b0, 8'h00);
    drv <= 8'h20;
    repeat (3) @(negedge i_clk);
    ap(r_int, 1'b0, 8'h01);
    ap(r_int, 1'b1, 8'h00);
    ap(r_int, 1'b0, 8'h01);
    ap(r_port, 1'b0, 8'h20);
    ap(r_int, 1'b1, 8'h00);
    ap(r_int, 1'b0, 8'h00);
    ap(r_port, 1'b1, 8'h40);
    ap(r_dir, 1'b1, 8'hbf);
    repeat (3) @(negedge i_clk);
    ap(r_int, 1'b0, 8'h00);
    ap(r_dir, 1'b1, 8'hff);
    $display("change test done");
  endtask : t_change

  task automatic t_ext;
    for (int s = 0; s < 2; s++) begin
      ap(r_opt, 1'b1, s ? 8'hff : 8'hbf);
      ap(r_int, 1'b1, 8'h00);
      drv[0] <= 1'b1;
      repeat (3) @(negedge i_clk);
      ap(r_int, 1'b0, {6'h0, s[0], 1'b0});
      ap(r_int, 1'b1, 8'h00);
      drv[0] <= 1'b0;
      repeat (3) @(negedge i_clk);
      ap(r_int, 1'b0, {6'h0, ~s[0], 1'b0});
    end
    $display("edge test done");
  endtask : t_ext

  task automatic t_irq;
    i_timer_overflow <= 1'b1;
    @(posedge i_clk);
    i_timer_overflow <= 1'b0;
    repeat (3) @(negedge i_clk);
    ap(r_int, 1'b0, 8'h04);
    chk("irq", {7'h0, o_irq}, 8'h00);
    wi(8'h24, 1'b0);
    wi(8'ha4, 1'b1);
    wi(8'h84, 1'b0);
    i_periph_irq <= 1'b1;
    wi(8'h80, 1'b0);
    wi(8'hc0, 1'b1);
    i_periph_irq <= 1'b0;
    drv <= 8'h21;
    wi(8'h92, 1'b1);
    drv <= 8'h30;
    wi(8'h08, 1'b0);
    chk("wake", {7'h0, o_wake}, 8'h01);
    ap(r_port, 1'b0, 8'h30);
    ap(r_int, 1'b1, 8'h00);
    ap(12'h3fc, 1'b0, 8'h00);
    chk("err", {7'h0, last_err}, 8'h01);
    $display("interrupt test done");
  endtask : t_irq

  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    {i_clk, i_rstn, i_psel, i_penable, i_pwrite, i_timer_overflow} = 6'h00;
    {i_periph_irq, i_paddr, i_pwdata, i_periph_dir_en, i_periph_dir} = 61'h0;
    {drv_en, drv, n_fail, n_compared} = {16'hff00, 64'h0};
    repeat (20) @(posedge i_clk);
    i_rstn <= 1'b1;
    @(negedge i_clk);
    t_reset();
    t_dir();
    t_change();
    t_ext();
    t_irq();
    give_verdict();
  end

  // Whole run is a few hundred cycles; this limit is far beyond it
  initial begin
    #(25 * 20000);
    n_fail++;
    give_verdict();
  end
endmodule : tb

`default_nettype wire
